//--- src/dseq_top.sv
// Overview of operation
// - Pin mode with the enable pin high converts pairs zero upward in order to the selected end pair; low, pair zero only.
// - Register mode offers 32 programmable steps pairing any A with any B.
// - No burst: one start pulse per step; burst: one pulse runs all steps.
// - Pin mode samples the enable pin at reset release; fixed until full reset.
// - Three end-channel pins, first pin MSB, give n; pairs zero to n run.
// - End selection taken at release, then reloaded during final busy pulse.
// - Software depth is 1 to 32, ending at the step with last flag set.
// - Each step converts the A and B channels named in its fields.
// - Register mode runs the stack only while config enable bit is one.
// - After the last step the next start pulse wraps to step zero.
// - Partial reset rewinds the step pointer, keeps all programmed values.
// - Burst starts on start rising edge; busy high until all steps done.
// - Burst results leave in programmed sequence order.
// - Pin burst only when burst and enable pins are both one at release.
// - Command word: bit 15 write, bits 14..9 address, bits 8..0 data.
// - Write has bit 15 one; read has bit 15 zero, data ignored.
// - Busy rises on a conversion after start edge, falls on completion.
module dseq_top
    import dseq_pkg::*;
#(
    parameter int STACK_DEPTH = 32,
    parameter int CONV_CYCLES = DSEQ_CONV_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pin_mode,
    input wire logic sequencer_enable,
    input wire logic burst_pin,
    input wire logic [2:0] end_channel_select,
    input wire logic partial_reset,
    input wire logic conversion_start,
    output logic busy,
    output logic pair_valid,
    output dseq_pair_t pair_out
);

    // ************************************************************
    // AHB-Lite slave: address phase capture
    // ************************************************************
    logic wr_pend_q;
    logic [7:0] addr_q;
    wire logic addr_take = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_take && hwrite;
            if (addr_take) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ************************************************************
    // Write decode; the command port carries the 16-bit word format
    // ************************************************************
    // Writes land in the data phase, when hwdata stands, at the captured address
    wire logic stack_hit = addr_q[7];
    wire logic [4:0] stack_idx = addr_q[6:2];
    wire logic [15:0] cmd_word = hwdata[15:0];
    wire logic cmd_wr = wr_pend_q && (addr_q == DSEQ_OFS_CMD);
    wire logic cmd_is_write = cmd_word[DSEQ_CMD_WRITE_BIT];
    wire logic [5:0] cmd_addr = cmd_word[DSEQ_CMD_WRITE_BIT-1:DSEQ_CMD_ADDR_LSB];
    wire logic [8:0] cmd_data = cmd_word[DSEQ_CMD_DATA_W-1:0];
    wire logic cmd_stack = cmd_addr[5];
    wire logic direct_cfg_wr = wr_pend_q && (addr_q == DSEQ_OFS_CONFIG);
    wire logic cmd_cfg_wr = cmd_wr && cmd_is_write && (cmd_addr == DSEQ_CMD_ADDR_CONFIG);
    // The bus carries one write at a time, so direct and command paths never collide
    wire logic cfg_wr = direct_cfg_wr || cmd_cfg_wr;
    wire logic [2:0] cfg_wdata = direct_cfg_wr ? hwdata[2:0] : cmd_data[2:0];
    wire logic step_direct_wr = wr_pend_q && stack_hit;
    wire logic step_cmd_wr = cmd_wr && cmd_is_write && cmd_stack;
    wire logic step_wr = step_direct_wr || step_cmd_wr;
    wire logic [4:0] step_widx = step_direct_wr ? stack_idx : cmd_addr[4:0];
    wire logic [8:0] step_wdata = step_direct_wr ? hwdata[8:0] : cmd_data;

    // ************************************************************
    // Configuration register and the 32-step stack
    // ************************************************************
    logic [2:0] cfg_q;
    logic [8:0] stack_q [STACK_DEPTH];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= DSEQ_CFG_RESET;
        end else if (cfg_wr) begin
            cfg_q <= cfg_wdata;
        end
    end

    // Stack contents survive a partial reset; only a full reset clears them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_q[i] <= DSEQ_STEP_RESET;
            end
        end else if (step_wr) begin
            stack_q[step_widx] <= step_wdata;
        end
    end

    // Read command latches register contents into the readback word
    logic [15:0] cmd_rdata_q;
    wire logic cmd_rd = cmd_wr && !cmd_is_write;
    wire logic [8:0] cmd_rsel = cmd_stack ? stack_q[cmd_addr[4:0]]
                              : (cmd_addr == DSEQ_CMD_ADDR_CONFIG) ? {6'h00, cfg_q} : 9'h000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_rdata_q <= 16'h0000;
        end else if (cmd_rd) begin
            cmd_rdata_q <= {1'b0, cmd_addr, cmd_rsel};
        end
    end

    // ************************************************************
    // Pin straps caught on the first clocked edge after release
    // ************************************************************
    logic strap_done_q;
    logic pin_mode_q;
    logic pin_seq_q;
    logic pin_burst_q;
    logic [2:0] end_sel_q;
    logic sel_reload;

    // Straps are taken once, so a pin that moves after release cannot alter the mode;
    // only the end-channel pins are read again, at the end of a pin-mode sequence
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_done_q <= 1'b0;
            pin_mode_q <= 1'b0;
            pin_seq_q <= 1'b0;
            pin_burst_q <= 1'b0;
            end_sel_q <= 3'h0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            pin_mode_q <= pin_mode;
            pin_seq_q <= sequencer_enable;
            pin_burst_q <= burst_pin && sequencer_enable;
            end_sel_q <= end_channel_select;
        end else if (sel_reload) begin
            end_sel_q <= end_channel_select;
        end
    end

    // ************************************************************
    // Effective mode
    // ************************************************************
    wire logic seq_on = pin_mode_q ? pin_seq_q : cfg_q[DSEQ_CFG_ENABLE_BIT];
    wire logic burst_on = seq_on && (pin_mode_q ? pin_burst_q : cfg_q[DSEQ_CFG_BURST_BIT]);
    wire logic soft_preset = cfg_wr && cfg_wdata[DSEQ_CFG_PRESET_BIT];
    wire logic rewind = partial_reset || soft_preset;

    // ************************************************************
    // Sequencer
    // ************************************************************
    dseq_state_t state_q;
    dseq_state_t state_d;
    logic [4:0] ptr_q;
    logic [4:0] ptr_d;
    logic [15:0] cnt_q;
    logic start_q;
    logic [15:0] result_q;

    // The detector resets low, the idle level of the start pin, so release starts nothing
    wire logic start_edge = conversion_start && !start_q;
    wire logic [8:0] cur_step = stack_q[ptr_q];
    wire logic hw_last = (ptr_q[2:0] == end_sel_q);
    wire logic sw_last = cur_step[DSEQ_STEP_LAST_BIT] || (ptr_q == 5'(STACK_DEPTH - 1));
    wire logic step_last = !seq_on || (pin_mode_q ? hw_last : sw_last);
    wire logic conv_done = (state_q == DSEQ_CONV) && (cnt_q == 16'(CONV_CYCLES - 1));
    wire logic [3:0] a_sel = pin_mode_q ? {1'b0, ptr_q[2:0]} : cur_step[DSEQ_STEP_A_LSB +: 4];
    wire logic [3:0] b_sel = pin_mode_q ? {1'b0, ptr_q[2:0]} : cur_step[DSEQ_STEP_B_LSB +: 4];
    wire logic [4:0] ptr_next = step_last ? 5'h00 : ptr_q + 5'h01;
    // New end pins are taken as the last pair completes, so no sequence changes length midway
    assign sel_reload = conv_done && pin_mode_q && step_last;

    // Next state: burst chains steps, otherwise wait for another start edge
    always_comb begin
        state_d = state_q;
        ptr_d = ptr_q;
        case (state_q)
            DSEQ_IDLE: begin
                if (start_edge) begin
                    state_d = DSEQ_CONV;
                end
            end
            DSEQ_CONV: begin
                if (conv_done) begin
                    ptr_d = seq_on ? ptr_next : 5'h00;
                    state_d = (burst_on && !step_last) ? DSEQ_NEXT : DSEQ_IDLE;
                end
            end
            DSEQ_NEXT: begin
                state_d = DSEQ_CONV;
            end
            default: begin
                state_d = DSEQ_IDLE;
            end
        endcase
        if (rewind) begin
            ptr_d = 5'h00;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= DSEQ_IDLE;
            ptr_q <= 5'h00;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ptr_q <= ptr_d;
            start_q <= conversion_start;
        end
    end

    // Conversion timer
    // It restarts from zero for every step, so each pair of a burst takes equally long
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 16'h0000;
        end else if (state_q == DSEQ_CONV && !conv_done) begin
            cnt_q <= cnt_q + 16'h0001;
        end else begin
            cnt_q <= 16'h0000;
        end
    end

    // Busy spans the whole burst, including the gap between steps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_d != DSEQ_IDLE);
        end
    end

    // One pair per completed step, emitted in sequence order
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pair_valid <= 1'b0;
            pair_out <= '0;
            result_q <= 16'h0000;
        end else begin
            pair_valid <= conv_done;
            if (conv_done) begin
                pair_out <= '{chan_a: a_sel, chan_b: b_sel, step: ptr_q};
                result_q <= {3'h0, ptr_q, b_sel, a_sel};
            end
        end
    end

    // ************************************************************
    // Read data mux, registered at the address phase
    // ************************************************************
    // The word is caught when the read is taken, so hrdata leaves a flop; a read placed
    // in the data phase of a write to the same register would still see the old value
    wire logic [7:0] rd_addr = haddr[7:0];
    wire logic rd_take = addr_take && !hwrite;
    wire logic [31:0] status_word = {22'h0, pin_mode_q, burst_on, seq_on, busy, ptr_q,
                                     state_q == DSEQ_IDLE};
    wire logic [31:0] rd_mux = rd_addr[7] ? {23'h0, stack_q[rd_addr[6:2]]}
                             : (rd_addr == DSEQ_OFS_CONFIG) ? {29'h0, cfg_q}
                             : (rd_addr == DSEQ_OFS_STATUS) ? status_word
                             : (rd_addr == DSEQ_OFS_RDATA) ? {16'h0, cmd_rdata_q}
                             : (rd_addr == DSEQ_OFS_RESULT) ? {16'h0, result_q}
                             : 32'h0000_0000;

    // Zero outside a read data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata <= rd_mux;
        end else begin
            hrdata <= 32'h0000_0000;
        end
    end

endmodule

//--- src/dseq_pkg.sv
package dseq_pkg;

    // ************************************************************
    // Register map (byte addresses on the AHB-Lite slave)
    // ************************************************************
    localparam logic [7:0] DSEQ_OFS_CONFIG = 8'h00;
    localparam logic [7:0] DSEQ_OFS_STATUS = 8'h04;
    localparam logic [7:0] DSEQ_OFS_CMD = 8'h08;
    localparam logic [7:0] DSEQ_OFS_RDATA = 8'h0C;
    localparam logic [7:0] DSEQ_OFS_RESULT = 8'h10;
    localparam logic [7:0] DSEQ_OFS_STACK = 8'h80;

    // ************************************************************
    // Configuration register fields
    // ************************************************************
    localparam int DSEQ_CFG_ENABLE_BIT = 0;
    localparam int DSEQ_CFG_BURST_BIT = 1;
    localparam int DSEQ_CFG_PRESET_BIT = 2;

    // ************************************************************
    // Stack step fields and command word layout
    // ************************************************************
    localparam int DSEQ_STEP_A_LSB = 0;
    localparam int DSEQ_STEP_B_LSB = 4;
    localparam int DSEQ_STEP_LAST_BIT = 8;
    localparam int DSEQ_CMD_WRITE_BIT = 15;
    localparam int DSEQ_CMD_ADDR_LSB = 9;
    localparam int DSEQ_CMD_DATA_W = 9;
    localparam logic [5:0] DSEQ_CMD_ADDR_CONFIG = 6'h02;
    localparam logic [5:0] DSEQ_CMD_ADDR_STACK = 6'h20;

    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic [8:0] DSEQ_STEP_RESET = 9'h000;
    localparam logic [2:0] DSEQ_CFG_RESET = 3'h0;
    localparam int DSEQ_CLK_MHZ = 10;
    localparam int DSEQ_CONV_NS = 500;
    localparam int DSEQ_CONV_CYC = (DSEQ_CONV_NS * DSEQ_CLK_MHZ + 999) / 1000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        DSEQ_IDLE,
        DSEQ_CONV,
        DSEQ_NEXT
    } dseq_state_t;

    typedef struct packed {
        logic [3:0] chan_a;
        logic [3:0] chan_b;
        logic [4:0] step;
    } dseq_pair_t;

endpackage

//--- sim/dseq_top_sva.sv
// ****
// Checker on the top ports
// ****
module dseq_top_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic hready,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic conversion_start,
    input wire logic busy,
    input wire logic pair_valid
);
    logic rd_q;
    // Tracks a read data phase, the only time hrdata may be non-zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) rd_q <= 1'h0;
        else rd_q <= hsel & hready & htrans[1] & !hwrite;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_edge;
        !conversion_start ##1 conversion_start;
    endsequence
    sequence s_conv;
        busy [*5];
    endsequence
    a_busy_rise: assert property (s_edge ##0 !busy |-> ##[0:2] busy)
        else $error("busy did not follow start edge");
    a_conv_len: assert property ($rose(busy) |-> s_conv)
        else $error("conversion shorter than five cycles");
    a_fall_valid: assert property ($fell(busy) |-> pair_valid)
        else $error("busy fell without a result");
    a_valid_pulse: assert property (pair_valid |=> !pair_valid)
        else $error("result strobe longer than one cycle");
    a_valid_busy: assert property (pair_valid |-> $past(busy))
        else $error("result without conversion");
    a_busy_cause: assert property ($rose(busy) |->
        $past(conversion_start) || $past(conversion_start, 2))
        else $error("busy rose without start");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("read data outside data phase");
endmodule

//--- sim/dseq_host.sv
// ****
// Host start-pulse model
// ****
module dseq_host (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic go,
    output logic conversion_start
);
    logic [1:0] cnt_q;
    // Two-cycle pulse so the device always sees a clean low-to-high edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt_q <= 2'h0;
        else if (go) cnt_q <= 2'h2;
        else if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
    end
    assign conversion_start = (cnt_q != 2'h0);
endmodule

//--- sim/tb_dual_adc_channel_sequencer.sv
// ****
// Sequencer bench
// ****
module tb_dual_adc_channel_sequencer
    import dseq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, go = 1'h0;
    logic pin_mode = 1'h0, sequencer_enable = 1'h0, burst_pin = 1'h0;
    logic partial_reset = 1'h0, cm = 1'h1;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, end_channel_select = 3'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'hD89C;
    logic [8:0] stk [3];
    wire logic hreadyout, hresp, conversion_start, busy, pair_valid;
    wire logic [31:0] hrdata;
    wire dseq_pair_t pair_out;
    dseq_pair_t exp_q [$];
    int n_errors = 0, n_checks = 0, i, k;

    always #50 hclk = ~hclk;

    dseq_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pin_mode(pin_mode), .sequencer_enable(sequencer_enable),
        .burst_pin(burst_pin), .end_channel_select(end_channel_select),
        .partial_reset(partial_reset), .conversion_start(conversion_start),
        .busy(busy), .pair_valid(pair_valid), .pair_out(pair_out));
    dseq_host host (.hclk(hclk), .hresetn(hresetn), .go(go),
        .conversion_start(conversion_start));

    // Repeatable random source for stack contents
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic dseq_pair_t pp(input logic [3:0] a, b, input logic [4:0] s);
        return {a, b, s};
    endfunction
    task final_report;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task tmo;
        n_errors++;
        $display("mismatch at %0t: timeout", $time);
        final_report;
    endtask
    // Bus answer is awaited, never assumed
    task wait_rdy;
        int j;
        @(posedge hclk);
        for (j = 0; hreadyout !== 1'h1; j++) begin
            if (j > 50) tmo;
            @(posedge hclk);
        end
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'h1; haddr <= a; htrans <= 2'h2; hwrite <= 1'h1;
        wait_rdy;
        hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
        wait_rdy;
    endtask
    task rd(input logic [31:0] a, input logic [31:0] e);
        hsel <= 1'h1; haddr <= a; htrans <= 2'h2; hwrite <= 1'h0;
        wait_rdy;
        hsel <= 1'h0; htrans <= 2'h0;
        wait_rdy;
        chk(hrdata, e);
    endtask
    // One start request, then every result checked until busy drops
    task conv(input int n);
        logic sb;
        dseq_pair_t e;
        int lim;
        sb = 1'h0;
        lim = (DSEQ_CONV_CYC + 1) * n + 20;
        k = 0;
        go <= 1'h1;
        @(posedge hclk);
        go <= 1'h0;
        for (i = 0; i < lim; i++) begin
            @(posedge hclk);
            #1;
            if (pair_valid === 1'h1) begin
                e = exp_q.pop_front();
                if (cm) chk(pair_out, e);
                else chk(pair_out.step, e.step);
                k++;
            end
            if (busy === 1'h1) sb = 1'h1;
            else if (sb) break;
        end
        if (i == lim) tmo;
        chk(k, n);
        @(posedge hclk);
    endtask
    task rst(input logic pm, sq, bp, input logic [2:0] es);
        pin_mode <= pm; sequencer_enable <= sq; burst_pin <= bp;
        end_channel_select <= es;
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (2) @(posedge hclk);
    endtask

    // Register mode first, then pin mode under fresh resets
    initial begin
        rst(1'h0, 1'h0, 1'h0, 3'h0);
        rd(DSEQ_OFS_CONFIG, DSEQ_CFG_RESET);
        rd(32'h40, 32'h0);
        for (int s = 0; s < 3; s++) begin
            seed = xs(seed);
            stk[s] = {s == 2, seed[7:0]};
            wr(DSEQ_OFS_STACK + 4 * s, stk[s]);
        end
        $display("test stack setup done");
        rd(DSEQ_OFS_STACK + 4, stk[1]);
        wr(DSEQ_OFS_CMD, {16'h0, 1'h1, DSEQ_CMD_ADDR_CONFIG, 9'h001});
        rd(DSEQ_OFS_CONFIG, 32'h1);
        wr(DSEQ_OFS_CMD, {16'h0, 1'h0, DSEQ_CMD_ADDR_STACK + 6'h1, 9'h1FF});
        rd(DSEQ_OFS_RDATA, {16'h0, 1'h0, DSEQ_CMD_ADDR_STACK + 6'h1, stk[1]});
        for (int s = 0; s < 5; s++) begin
            exp_q.push_back(pp(stk[s % 3][3:0], stk[s % 3][7:4], 5'(s % 3)));
            conv(1);
        end
        partial_reset <= 1'h1;
        @(posedge hclk);
        partial_reset <= 1'h0;
        @(posedge hclk);
        exp_q.push_back(pp(stk[0][3:0], stk[0][7:4], 5'h0));
        conv(1);
        rd(DSEQ_OFS_RESULT, {24'h0, stk[0][7:0]});
        rd(DSEQ_OFS_STACK + 4, stk[1]);
        $display("test stepping done");
        wr(DSEQ_OFS_CONFIG, 32'h7);
        for (int s = 0; s < 3; s++) exp_q.push_back(pp(stk[s][3:0], stk[s][7:4], 5'(s)));
        conv(3);
        wr(DSEQ_OFS_CONFIG, 32'h0);
        cm = 1'h0;
        for (int s = 0; s < 2; s++) begin
            exp_q.push_back(pp(4'h0, 4'h0, 5'h0));
            conv(1);
        end
        $display("test burst done");
        cm = 1'h1;
        rst(1'h1, 1'h1, 1'h0, 3'h2);
        for (int s = 0; s < 5; s++) begin
            k = (s < 3) ? s : 0;
            exp_q.push_back(pp(4'(k), 4'(k), 5'(k)));
            if (s == 2) end_channel_select <= 3'h0;
            conv(1);
        end
        rst(1'h1, 1'h1, 1'h1, 3'h1);
        rd(DSEQ_OFS_STATUS, 32'h381);
        end_channel_select <= 3'h3;
        for (int s = 0; s < 2; s++) exp_q.push_back(pp(4'(s), 4'(s), 5'(s)));
        conv(2);
        for (int s = 0; s < 4; s++) exp_q.push_back(pp(4'(s), 4'(s), 5'(s)));
        conv(4);
        rst(1'h1, 1'h0, 1'h1, 3'h3);
        rd(DSEQ_OFS_STATUS, 32'h201);
        exp_q.push_back(pp(4'h0, 4'h0, 5'h0));
        conv(1);
        $display("test pin mode done");
        final_report;
    end
endmodule

bind dseq_top dseq_top_sva sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .hready(hready), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .conversion_start(conversion_start),
    .busy(busy), .pair_valid(pair_valid));
